// ### css_command_source_selector.v
// command source selector with option warning word and store trigger
`timescale 1ns/1ns
`include "css_defs.vh"

module css_command_source_selector (
	// clock and reset
	input  wire        mclk,
	input  wire        srst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// requests: bit 0 brake, 1 start, 2 reverse, 3 set-up, 4 preset
	input  wire [4:0]  busReq,
	input  wire [4:0]  termReq,
	// combined function requests, all zero when selectors are inactive, and selector-active flag
	output reg  [4:0]  funcReq,
	output reg         selActive,
	// warning event sources
	input  wire [15:0] warnEvent,
	// nonvolatile store handshake
	output reg         storeBusy,
	input  wire        storeDone,
	// interrupt
	output wire        irq
);

	reg  [9:0]  srcSel_q;
	reg  [1:0]  ctrlSite_q;
	reg  [15:0] warn_q;
	reg  [1:0]  store_q;
	reg  [1:0]  irqStat_q;
	reg  [1:0]  irqEn_q;
	reg  [4:0]  busReq_q;
	reg  [4:0]  termReq_q;
	wire [4:0]  comb;
	reg  [15:0] warnPrev_q;
	wire        wrEn;
	wire        rdEn;
	wire        mapped;
	wire        storeStart;
	wire        storeFin;
	wire [15:0] warnRise;
	wire [1:0]  irqSet;

	// combine one bus and one terminal request by selector code
	function combine;
		input [1:0] sel;
		input       b;
		input       t;
		begin
			case (sel)
				`CSS_SEL_TERM: combine = t;
				`CSS_SEL_BUS:  combine = b;
				`CSS_SEL_AND:  combine = b & t;
				`CSS_SEL_OR:   combine = b | t;
				default:       combine = 1'b0;
			endcase
		end
	endfunction

	function isMapped;
		input [11:0] a;
		begin
			case (a)
				`CSS_OFF_SRCSEL, `CSS_OFF_CTRLSITE, `CSS_OFF_WARN,
				`CSS_OFF_STORE, `CSS_OFF_IRQSTAT, `CSS_OFF_IRQEN,
				`CSS_OFF_IRQCLR: isMapped = 1'b1;
				default:         isMapped = 1'b0;
			endcase
		end
	endfunction

	assign pready  = 1'b1;
	assign mapped  = isMapped(paddr);
	assign pslverr = psel & penable & ~mapped;
	assign wrEn    = psel & penable & pwrite & mapped;
	assign rdEn    = psel & ~penable & ~pwrite;

	// request capture in the local clock domain
	always @(posedge mclk) begin
		if (srst) begin
			busReq_q  <= 5'h00;
			termReq_q <= 5'h00;
		end else begin
			busReq_q  <= busReq;
			termReq_q <= termReq;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : gSel
			assign comb[gi] = combine(srcSel_q[2*gi+1:2*gi], busReq_q[gi],
				termReq_q[gi]);
		end
	endgenerate

	// outputs registered; inactive selectors pass nothing
	always @(posedge mclk) begin
		if (srst) begin
			funcReq   <= 5'h00;
			selActive <= 1'b0;
		end else begin
			selActive <= (ctrlSite_q == `CSS_SITE_TERM_WORD);
			if (ctrlSite_q == `CSS_SITE_TERM_WORD)
				funcReq <= comb;
			else
				funcReq <= 5'h00;
		end
	end

	// selector, control-site and interrupt-enable registers
	always @(posedge mclk) begin
		if (srst) begin
			srcSel_q   <= `CSS_SRCSEL_RST;
			ctrlSite_q <= `CSS_CTRLSITE_RST;
			irqEn_q    <= 2'h0;
		end else if (wrEn) begin
			if (paddr == `CSS_OFF_SRCSEL)
				srcSel_q <= pwdata[9:0];
			if (paddr == `CSS_OFF_CTRLSITE)
				ctrlSite_q <= pwdata[1:0];
			if (paddr == `CSS_OFF_IRQEN)
				irqEn_q <= pwdata[1:0];
		end
	end

	// warning word: follows the event inputs each cycle, reserved bits held at zero
	always @(posedge mclk) begin
		if (srst) begin
			warn_q     <= `CSS_WARN_RST;
			warnPrev_q <= 16'h0000;
		end else begin
			warnPrev_q <= warnEvent & `CSS_WARN_RSVD_MASK;
			warn_q     <= warnEvent & `CSS_WARN_RSVD_MASK;
		end
	end
	assign warnRise = warnEvent & `CSS_WARN_RSVD_MASK & ~warnPrev_q;

	// store control, self-clearing on completion
	assign storeStart = wrEn & (paddr == `CSS_OFF_STORE) &
		(pwdata[1:0] == `CSS_STORE_ALL) & (store_q == `CSS_STORE_IDLE);
	assign storeFin   = storeBusy & storeDone;
	always @(posedge mclk) begin
		if (srst) begin
			store_q   <= `CSS_STORE_IDLE;
			storeBusy <= 1'b0;
		end else if (storeStart) begin
			store_q   <= `CSS_STORE_ALL;
			storeBusy <= 1'b1;
		end else if (storeFin) begin
			store_q   <= `CSS_STORE_IDLE;
			storeBusy <= 1'b0;
		end
	end

	// interrupt status: set wins over clear
	assign irqSet = {storeFin, |warnRise};
	always @(posedge mclk) begin
		if (srst)
			irqStat_q <= 2'h0;
		else if (wrEn && paddr == `CSS_OFF_IRQCLR)
			irqStat_q <= (irqStat_q & ~pwdata[1:0]) | irqSet;
		else
			irqStat_q <= irqStat_q | irqSet;
	end
	assign irq = |(irqStat_q & irqEn_q);

	// read data captured in setup phase
	always @(posedge mclk) begin
		if (srst)
			prdata <= 32'h00000000;
		else if (rdEn) begin
			case (paddr)
				`CSS_OFF_SRCSEL:   prdata <= {22'h000000, srcSel_q};
				`CSS_OFF_CTRLSITE: prdata <= {30'h00000000, ctrlSite_q};
				`CSS_OFF_WARN:     prdata <= {16'h0000, warn_q};
				`CSS_OFF_STORE:    prdata <= {30'h00000000, store_q};
				`CSS_OFF_IRQSTAT:  prdata <= {30'h00000000, irqStat_q};
				`CSS_OFF_IRQEN:    prdata <= {30'h00000000, irqEn_q};
				default:           prdata <= 32'h00000000;
			endcase
		end
	end

endmodule // css_command_source_selector

// ### css_defs.vh
// register map, field layout and reset values of the command source selector
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH
`define CSS_OFF_SRCSEL      12'h000
`define CSS_OFF_CTRLSITE    12'h004
`define CSS_OFF_WARN        12'h008
`define CSS_OFF_STORE       12'h00C
`define CSS_OFF_IRQSTAT     12'h010
`define CSS_OFF_IRQEN       12'h014
`define CSS_OFF_IRQCLR      12'h018
`define CSS_SEL_TERM        2'h0
`define CSS_SEL_BUS         2'h1
`define CSS_SEL_AND         2'h2
`define CSS_SEL_OR          2'h3
`define CSS_SRCSEL_RST      10'h3CF
`define CSS_CTRLSITE_RST    2'h0
`define CSS_SITE_TERM_WORD  2'h0
`define CSS_WARN_RST        16'h0000
`define CSS_WARN_RSVD_MASK  16'hFE1F
`define CSS_STORE_IDLE      2'h0
`define CSS_STORE_ALL       2'h2
`define CSS_IRQ_WARN_BIT    0
`define CSS_IRQ_STORE_BIT   1
`endif

// ### css_props.sv
// port assertions for the command source selector
`timescale 1ns/1ns
module css_props (
	// clock, reset, apb phase
	input wire logic       mclk,
	input wire logic       srst,
	input wire logic       psel,
	input wire logic       penable,
	// requests and store
	input wire logic [4:0] busReq,
	input wire logic [4:0] termReq,
	input wire logic [4:0] funcReq,
	input wire logic       selActive,
	input wire logic       storeBusy,
	input wire logic       storeDone
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	property p_on;
		selActive && $past(selActive) && $past(selActive, 2) &&
		!$past(srst) && !$past(srst, 2) |->
		($past(busReq & termReq, 2) & ~funcReq) == 5'h00;
	endproperty
	property p_off; (funcReq & ~$past(busReq | termReq, 2)) == 5'h00; endproperty
	property p_site; !selActive [*3] |-> funcReq == 5'h00; endproperty
	property p_rst; $fell(srst) |-> funcReq == 5'h00 && !storeBusy; endproperty
	property p_go; $rose(storeBusy) |-> $past(psel && penable); endproperty
	property p_end; storeBusy && storeDone |=> !storeBusy; endproperty
	property p_stay; $fell(storeBusy) && !$past(srst) |-> $past(storeDone);
	endproperty
	property p_idle; !storeBusy && !psel |=> !storeBusy; endproperty
	a_on: assert property (p_on) else $error("lost request");
	a_off: assert property (p_off) else $error("stray request");
	a_site: assert property (p_site) else $error("site off");
	a_rst: assert property (p_rst) else $error("reset value");
	a_go: assert property (p_go) else $error("store start");
	a_end: assert property (p_end) else $error("store end");
	a_stay: assert property (p_stay) else $error("store cut");
	a_idle: assert property (p_idle) else $error("store self");
	c_store: cover property (storeBusy && storeDone);
	c_site: cover property (!selActive);
	c_all: cover property (funcReq == 5'h1F);
endmodule // css_props
bind css_command_source_selector css_props u_props (.*);

// ### css_nv_model.sv
// memory stand-in that ends a store after a few cycles
`timescale 1ns/1ns
module css_nv_model (
	// store handshake
	input  wire logic mclk,
	input  wire logic storeBusy,
	output logic      storeDone = 1'b0
);
	logic [2:0] cntQ = 3'h0;
	always @(posedge mclk) begin
		cntQ <= storeBusy ? cntQ + 3'h1 : 3'h0;
		storeDone <= storeBusy && cntQ == 3'h5;
	end
endmodule // css_nv_model

// ### css_command_source_selector_tb.sv
// self-checking bench for the command source selector
`timescale 1ns/1ns
`include "css_defs.vh"
module css_command_source_selector_tb;
	logic        mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic [15:0] warnEvent = '0;
	logic [9:0]  s;
	logic [4:0]  busReq = '0, termReq = '0, funcReq, x;
	logic [3:0]  v;
	logic        pready, pslverr, selActive, storeBusy, storeDone, irq, se;
	int          errors = 0, checks_done = 0, i, j, k, m;
	css_command_source_selector uut (.*);
	css_nv_model mem (.*);
	initial forever #20 mclk = ~mclk;
	task chk(input logic [31:0] g, e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge mclk);
		penable <= 1'b1;
		i = 0;
		do @(posedge mclk); while (pready !== 1'b1 && ++i < 20);
		r = prdata;
		se = pslverr;
		{psel, penable} <= 2'h0;
		chk(i < 20, 1'b1);
		if (i >= 20) finish_test;
		@(negedge mclk);
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		warnEvent <= 16'hFFFF;
		apb(1'b0, `CSS_OFF_SRCSEL, '0);
		chk(r, 10'h3CF);
		chk(se, 1'b0);
		for (m = 0; m < 4; m++) begin
			for (j = 0; j < 5; j++) s[2*j+:2] = 2'(m + j);
			apb(1'b1, `CSS_OFF_SRCSEL, s);
			for (k = 0; k < 4; k++) begin
				@(posedge mclk);
				{busReq, termReq} <= {{5{k[1]}}, {5{k[0]}}};
				repeat (3) @(negedge mclk);
				v = {k[1] | k[0], k[1] & k[0], k[1], k[0]};
				for (j = 0; j < 5; j++) x[j] = v[s[2*j+:2]];
				chk(funcReq, x);
			end
		end
		apb(1'b1, `CSS_OFF_CTRLSITE, 32'h1);
		repeat (3) @(negedge mclk);
		chk({selActive, funcReq}, 6'h00);
		apb(1'b1, `CSS_OFF_CTRLSITE, `CSS_SITE_TERM_WORD);
		$display("selector tests done");
		apb(1'b0, `CSS_OFF_WARN, '0);
		chk(r, `CSS_WARN_RSVD_MASK);
		chk(irq, 1'b0);
		apb(1'b1, `CSS_OFF_IRQEN, 32'h3);
		chk(irq, 1'b1);
		apb(1'b1, `CSS_OFF_IRQCLR, 32'h1);
		chk(irq, 1'b0);
		apb(1'b1, `CSS_OFF_STORE, 32'h1);
		chk(storeBusy, 1'b0);
		apb(1'b1, `CSS_OFF_STORE, `CSS_STORE_ALL);
		apb(1'b0, `CSS_OFF_STORE, '0);
		chk(r, `CSS_STORE_ALL);
		for (i = 0; i < 50 && storeBusy; i++) @(negedge mclk);
		chk(storeBusy, 1'b0);
		if (storeBusy) finish_test;
		apb(1'b0, `CSS_OFF_STORE, '0);
		chk(r, `CSS_STORE_IDLE);
		chk(irq, 1'b1);
		apb(1'b0, 12'hFFC, '0);
		chk(r, 32'h0);
		chk(se, 1'b1);
		$display("warning and store tests done");
		finish_test;
	end
endmodule // css_command_source_selector_tb
